/* File: hw/crs_defines.svh */
// Register offsets, field positions, reset values and sync timing of the common synchronizer
`ifndef CRS_DEFINES_SVH
`define CRS_DEFINES_SVH

`define CRS_ADDR_W 8
`define CRS_OFS_CTRL 8'h00
`define CRS_OFS_STATUS 8'h04
`define CRS_OFS_RD_REQ 8'h08
`define CRS_OFS_SCRATCH 8'h0C
`define CRS_OFS_CORE_CFG 8'h10
`define CRS_OFS_CORE_CNT 8'h14

`define CRS_CTRL_SOFT_RST 0
`define CRS_CTRL_ENABLE 1
`define CRS_STATUS_PEND 0
`define CRS_RD_REQ_ADDR_MSB 7
`define CRS_RD_REQ_CONT 14
`define CRS_RD_REQ_ONE 15

`define CRS_RST_WORD 32'h0000_0000
`define CRS_SYNC_EDGES 3'h6

`endif

/* File: hw/crs_pkg.sv */
// Types shared by the common register synchronizer
package crs_pkg;
	typedef enum logic [4:0] {
		CRS_ST_IDLE = 5'h01,
		CRS_ST_WR = 5'h02,
		CRS_ST_RD = 5'h04,
		CRS_ST_ONE_SHOT = 5'h08,
		CRS_ST_CONT = 5'h10
	} crs_state_t;
endpackage : crs_pkg

/* File: hw/crs_sync.sv */
// Common register synchronizer between the bus clock and the generic clock core
//
// Function
// - One shared engine; only one core register synchronizes at a time.
// - Every core write and read-synced read crosses via generic clock edges, even at equal clocks.
// - Bus-domain registers answer at once, except writes during an enable sync.
// - Core register write starts a write sync; pending set at start, cleared at end.
// - During write sync, stall core writes, read-synced reads, reads of the written core configuration register.
// - During write sync, other core reads and bus-domain reads do not stall.
// - Read-synced read stalls until its sync ends; pending stays untouched.
// - Read-synced read during pending waits first, then stalls for its own sync.
// - Completion shows as pending flag clearing.
// - Access arriving during a sync is held and started automatically afterwards.
// - Read request register exists only when the build enables it.
// - One-shot request syncs the addressed register and sets pending until done.
// - One-shot value stays readable at once until a new one-shot or continuous request.
// - Request address field holds the byte offset from the block base.
// - Continuous request keeps resynchronizing the addressed register.
// - Continuous mode sets pending only for its first synchronization.
// - Any other sync stops continuous reading; software restarts it.
// - Continuous reading pauses while the generic clock stands still.
// - Enable write starts a write sync and reads back the new value at once.
// - Enable sync completion raises no ready event; pending alone marks it.
// - During enable sync, stall core writes, bus-domain writes, read-synced reads.
// - During enable sync, bus-domain reads do not stall.
// - Software reset bit set by writing one, reads one, cleared with pending at end.
// - A sync spans six detected generic clock edges plus bus-side sampling.
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "crs_defines.svh"
`default_nettype none

module crs_sync import crs_pkg::*; #(
	parameter bit HAS_RD_REQ = 1'b1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic generic_clock_controller,
	input wire logic [`CRS_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic core_enable,
	output logic [31:0] core_cfg,
	output logic core_reset,
	output logic sync_pending
);

	logic rst_s1_q;
	logic rst_n_q;
	logic generic_clock_controller_s1_q;
	logic generic_clock_controller_s2_q;
	logic generic_clock_controller_s3_q;
	logic gedge;
	crs_state_t st_q;
	logic [2:0] cnt_q;
	logic done;
	logic busy;
	logic en_busy;
	logic pend_q;
	logic wr_tgt_q;
	logic [31:0] wr_data_q;
	logic soft_rst_q;
	logic ctrl_en_q;
	logic [31:0] cfg_bus_q;
	logic [31:0] scratch_q;
	logic [7:0] rr_addr_q;
	logic rr_cont_q;
	logic rr_valid_q;
	logic [31:0] rr_val_q;
	logic [31:0] rd_cap_q;
	logic rd_done_q;
	logic core_en_q;
	logic [31:0] core_cfg_q;
	logic [31:0] core_cnt_q;
	logic core_reset_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic req;
	logic ack;
	logic use_rd;
	logic start_wr;
	logic start_rd;
	logic start_one;
	logic start_cont;
	logic wr_ctrl;
	logic wr_cfg;
	logic wr_scratch;
	logic wr_rr;
	logic [31:0] mask;
	logic [31:0] wd;
	logic [31:0] rdata;
	logic [31:0] sel_val;

	// Reset release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// Generic clock sampled and edge found
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			generic_clock_controller_s1_q <= 1'b0;
			generic_clock_controller_s2_q <= 1'b0;
			generic_clock_controller_s3_q <= 1'b0;
		end else begin
			generic_clock_controller_s1_q <= generic_clock_controller;
			generic_clock_controller_s2_q <= generic_clock_controller_s1_q;
			generic_clock_controller_s3_q <= generic_clock_controller_s2_q;
		end
	end
	assign gedge = generic_clock_controller_s2_q & ~generic_clock_controller_s3_q;

	assign done = (st_q != CRS_ST_IDLE) && gedge && (cnt_q == `CRS_SYNC_EDGES - 3'h1);
	// Quiet continuous resync may be pre-empted
	assign busy = (st_q != CRS_ST_IDLE) && !((st_q == CRS_ST_CONT) && !pend_q);
	assign en_busy = (st_q == CRS_ST_WR) && wr_tgt_q;
	assign mask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
	assign wd = writedata & mask;
	assign req = (read || write) && wait_q;

	always_comb begin
		case (rr_addr_q)
			`CRS_OFS_CORE_CNT: sel_val = core_cnt_q;
			`CRS_OFS_CORE_CFG: sel_val = core_cfg_q;
			default: sel_val = 32'h0000_0000;
		endcase
	end

	// Access decode; a held request is retried every cycle
	always_comb begin
		ack = 1'b0;
		use_rd = 1'b0;
		start_wr = 1'b0;
		start_rd = 1'b0;
		start_one = 1'b0;
		start_cont = 1'b0;
		wr_ctrl = 1'b0;
		wr_cfg = 1'b0;
		wr_scratch = 1'b0;
		wr_rr = 1'b0;
		rdata = 32'h0000_0000;
		if (req && write) begin
			case (address)
				`CRS_OFS_CTRL: begin
					if (!busy) begin
						ack = 1'b1;
						start_wr = 1'b1;
						wr_ctrl = 1'b1;
					end
				end
				`CRS_OFS_CORE_CFG: begin
					if (!busy) begin
						ack = 1'b1;
						start_wr = 1'b1;
						wr_cfg = 1'b1;
					end
				end
				`CRS_OFS_SCRATCH: begin
					if (!en_busy) begin
						ack = 1'b1;
						wr_scratch = 1'b1;
					end
				end
				`CRS_OFS_RD_REQ: begin
					if (!HAS_RD_REQ) begin
						ack = 1'b1;
					end else if (en_busy) begin
						ack = 1'b0;
					end else if (wd[`CRS_RD_REQ_ONE] || wd[`CRS_RD_REQ_CONT]) begin
						if (!busy) begin
							ack = 1'b1;
							wr_rr = 1'b1;
							start_cont = wd[`CRS_RD_REQ_CONT];
							start_one = !wd[`CRS_RD_REQ_CONT];
						end
					end else begin
						ack = 1'b1;
						wr_rr = 1'b1;
					end
				end
				default: ack = 1'b1;
			endcase
		end else if (req) begin
			case (address)
				`CRS_OFS_CTRL: begin
					ack = 1'b1;
					rdata[`CRS_CTRL_SOFT_RST] = soft_rst_q;
					rdata[`CRS_CTRL_ENABLE] = ctrl_en_q;
				end
				`CRS_OFS_STATUS: begin
					ack = 1'b1;
					rdata[`CRS_STATUS_PEND] = pend_q;
				end
				`CRS_OFS_SCRATCH: begin
					ack = 1'b1;
					rdata = scratch_q;
				end
				`CRS_OFS_RD_REQ: begin
					ack = 1'b1;
					if (HAS_RD_REQ) begin
						rdata[`CRS_RD_REQ_CONT] = rr_cont_q;
						rdata[`CRS_RD_REQ_ADDR_MSB:0] = rr_addr_q;
					end
				end
				`CRS_OFS_CORE_CFG: begin
					if (!((st_q == CRS_ST_WR) && !wr_tgt_q)) begin
						ack = 1'b1;
						rdata = cfg_bus_q;
					end
				end
				`CRS_OFS_CORE_CNT: begin
					if (HAS_RD_REQ && rr_valid_q && (rr_addr_q == `CRS_OFS_CORE_CNT)) begin
						ack = 1'b1;
						rdata = rr_val_q;
					end else if (rd_done_q) begin
						ack = 1'b1;
						use_rd = 1'b1;
						rdata = rd_cap_q;
					end else if (!busy) begin
						start_rd = 1'b1;
					end
				end
				default: ack = 1'b1;
			endcase
		end
	end

	// Shared sync engine
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= CRS_ST_IDLE;
			cnt_q <= 3'h0;
		end else if (start_wr) begin
			st_q <= CRS_ST_WR;
			cnt_q <= 3'h0;
		end else if (start_rd) begin
			st_q <= CRS_ST_RD;
			cnt_q <= 3'h0;
		end else if (start_one) begin
			st_q <= CRS_ST_ONE_SHOT;
			cnt_q <= 3'h0;
		end else if (start_cont) begin
			st_q <= CRS_ST_CONT;
			cnt_q <= 3'h0;
		end else if (done) begin
			cnt_q <= 3'h0;
			st_q <= (st_q == CRS_ST_CONT) ? CRS_ST_CONT : CRS_ST_IDLE;
		end else if ((st_q != CRS_ST_IDLE) && gedge) begin
			cnt_q <= cnt_q + 3'h1;
		end
	end

	// Pending flag; a start wins over a completion
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pend_q <= 1'b0;
		end else if (start_wr || start_one || start_cont) begin
			pend_q <= 1'b1;
		end else if (done) begin
			pend_q <= 1'b0;
		end
	end

	// Posted write payload
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wr_tgt_q <= 1'b0;
			wr_data_q <= `CRS_RST_WORD;
		end else if (start_wr) begin
			wr_tgt_q <= wr_ctrl;
			wr_data_q <= wr_ctrl ? wd : ((cfg_bus_q & ~mask) | wd);
		end
	end

	// Bus-side copies
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			soft_rst_q <= 1'b0;
			ctrl_en_q <= 1'b0;
			cfg_bus_q <= `CRS_RST_WORD;
			scratch_q <= `CRS_RST_WORD;
		end else begin
			if (wr_ctrl) begin
				soft_rst_q <= soft_rst_q | wd[`CRS_CTRL_SOFT_RST];
				if (byteenable[0]) begin
					ctrl_en_q <= wd[`CRS_CTRL_ENABLE];
				end
			end else if (done && (st_q == CRS_ST_WR) && wr_tgt_q && soft_rst_q) begin
				soft_rst_q <= 1'b0;
				ctrl_en_q <= 1'b0;
				cfg_bus_q <= `CRS_RST_WORD;
			end
			if (wr_cfg) begin
				cfg_bus_q <= (cfg_bus_q & ~mask) | wd;
			end
			if (wr_scratch) begin
				scratch_q <= (scratch_q & ~mask) | wd;
			end
		end
	end

	// Core registers, moved only on generic clock edges
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			core_en_q <= 1'b0;
			core_cfg_q <= `CRS_RST_WORD;
			core_cnt_q <= `CRS_RST_WORD;
			core_reset_q <= 1'b0;
		end else begin
			core_reset_q <= 1'b0;
			if (done && (st_q == CRS_ST_WR) && wr_tgt_q && soft_rst_q) begin
				core_en_q <= 1'b0;
				core_cfg_q <= `CRS_RST_WORD;
				core_cnt_q <= `CRS_RST_WORD;
				core_reset_q <= 1'b1;
			end else begin
				if (done && (st_q == CRS_ST_WR)) begin
					if (wr_tgt_q) begin
						core_en_q <= wr_data_q[`CRS_CTRL_ENABLE];
					end else begin
						core_cfg_q <= wr_data_q;
					end
				end
				if (gedge && core_en_q) begin
					core_cnt_q <= core_cnt_q + 32'h0000_0001;
				end
			end
		end
	end

	// Read request state
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rr_addr_q <= 8'h00;
			rr_cont_q <= 1'b0;
			rr_valid_q <= 1'b0;
			rr_val_q <= `CRS_RST_WORD;
		end else begin
			if (wr_rr && byteenable[0]) begin
				rr_addr_q <= wd[`CRS_RD_REQ_ADDR_MSB:0];
			end
			if (start_cont) begin
				rr_cont_q <= 1'b1;
			end else if (start_wr || start_rd || start_one) begin
				rr_cont_q <= 1'b0;
			end
			if (start_one || start_cont) begin
				rr_valid_q <= 1'b0;
			end else if (done && ((st_q == CRS_ST_ONE_SHOT) || (st_q == CRS_ST_CONT))) begin
				rr_valid_q <= 1'b1;
				rr_val_q <= sel_val;
			end
		end
	end

	// Stalling read capture
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rd_cap_q <= `CRS_RST_WORD;
			rd_done_q <= 1'b0;
		end else if (done && (st_q == CRS_ST_RD)) begin
			rd_cap_q <= core_cnt_q;
			rd_done_q <= 1'b1;
		end else if (use_rd) begin
			rd_done_q <= 1'b0;
		end
	end

	// Bus answer
	always_ff @(posedge clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= !ack;
			if (ack) begin
				rdata_q <= rdata;
			end
		end
	end

	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign core_enable = core_en_q;
	assign core_cfg = core_cfg_q;
	assign core_reset = core_reset_q;
	assign sync_pending = pend_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_q);

	sequence s_core_wr_taken;
		start_wr && !busy;
	endsequence

	sequence s_sync_end;
		##[9:1000] (done && (st_q == CRS_ST_WR));
	endsequence

	a_pend_on_write: assert property (s_core_wr_taken |=> pend_q)
		else $error("pending not set by core write");
	a_write_len: assert property (s_core_wr_taken |-> s_sync_end)
		else $error("write sync did not end in time");
	a_wr_stall: assert property (req && write && (address == `CRS_OFS_CORE_CFG) && busy
		|=> waitrequest)
		else $error("core write not stalled");
	a_bus_now: assert property (req && read && (address == `CRS_OFS_SCRATCH)
		|=> !waitrequest ##1 waitrequest)
		else $error("bus register read not immediate");
	a_en_stall: assert property (req && write && (address == `CRS_OFS_SCRATCH) && en_busy
		|=> waitrequest)
		else $error("bus write not stalled in enable sync");
	a_rd_quiet: assert property (((st_q == CRS_ST_RD) && !pend_q) |=> !pend_q)
		else $error("read sync set pending");
	a_cont_quiet: assert property (((st_q == CRS_ST_CONT) && !pend_q && !start_wr
		&& !start_one && !start_cont) |=> !pend_q)
		else $error("continuous resync set pending");
	a_cont_stop: assert property ((start_wr && (st_q == CRS_ST_CONT))
		|=> (st_q == CRS_ST_WR) && !rr_cont_q)
		else $error("continuous read not stopped");
	a_done_clear: assert property ((done && !start_wr && !start_one && !start_cont)
		|=> !pend_q)
		else $error("pending not cleared at completion");
	a_soft_rst_read: assert property ((wr_ctrl && wd[`CRS_CTRL_SOFT_RST])
		|=> soft_rst_q until (done && (st_q == CRS_ST_WR)))
		else $error("software reset bit not held");
	a_soft_rst_bound: assert property ((wr_ctrl && wd[`CRS_CTRL_SOFT_RST])
		|=> soft_rst_q ##[8:999] !soft_rst_q)
		else $error("software reset never finished");

endmodule : crs_sync

`default_nettype wire

/* File: bench/crs_generic_clock_controller_model.sv */
// Generic clock source that can be stopped as in a sleep mode
`timescale 1ns/1ps
`default_nettype none

module crs_generic_clock_controller_model #(
	parameter int HALF_NS = 80
) (
	input wire logic run,
	output logic generic_clock_controller
);
	// Odd start offset keeps it unrelated in phase to the bus clock
	initial begin
		generic_clock_controller = 1'b0;
		#37;
		forever begin
			#HALF_NS;
			if (run || generic_clock_controller) generic_clock_controller = ~generic_clock_controller;
		end
	end
endmodule : crs_generic_clock_controller_model

`default_nettype wire

/* File: bench/common_register_synchronizer_tb_top.sv */
// Bus-side tests of the common register synchronizer
`timescale 1ns/1ps
`include "crs_defines.svh"
`default_nettype none

module common_register_synchronizer_tb_top;
	logic clk;
	logic resetn;
	logic run;
	logic generic_clock_controller;
	logic [7:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [3:0] byteenable;
	logic [31:0] readdata;
	logic waitrequest;
	logic core_enable;
	logic [31:0] core_cfg;
	logic core_reset;
	logic sync_pending;
	int err_count;
	int check_count;
	int cyc;
	int pend_cnt = 0;
	int rst_cnt = 0;
	int p;
	logic [31:0] q;
	logic [31:0] v;

	crs_generic_clock_controller_model gen (.run(run), .generic_clock_controller(generic_clock_controller));

	crs_sync dut (
		.clk(clk), .resetn(resetn), .generic_clock_controller(generic_clock_controller), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .core_enable(core_enable),
		.core_cfg(core_cfg), .core_reset(core_reset), .sync_pending(sync_pending)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycles with the pending flag high
	always @(posedge clk) begin
		if (sync_pending === 1'b1) pend_cnt <= pend_cnt + 1;
	end

	// Finished software resets seen on the core side
	always @(posedge clk) begin
		if (core_reset === 1'b1) rst_cnt <= rst_cnt + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One bus access; cyc counts edges until waitrequest is seen low
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc = 0;
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
			cyc++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : acc

	task automatic wait_idle;
		int k;
		k = 0;
		while (sync_pending !== 1'b0 && k < 400) begin
			@(posedge clk);
			k++;
		end
	endtask : wait_idle

	task automatic close_out;
		if (err_count == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : close_out

	initial begin
		resetn = 1'b0;
		run = 1'b1;
		address = 8'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		byteenable = 4'hF;
		err_count = 0;
		check_count = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		acc(1'b0, `CRS_OFS_STATUS, 32'h0);
		chk(q, 32'h0);
		acc(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		chk(32'(cyc), 32'h2);
		acc(1'b1, `CRS_OFS_SCRATCH, 32'hA5A5_5A5A);
		chk(32'(cyc), 32'h2);
		acc(1'b0, `CRS_OFS_SCRATCH, 32'h0);
		chk(q, 32'hA5A5_5A5A);
		acc(1'b1, `CRS_OFS_CORE_CFG, 32'h1234_5678);
		acc(1'b0, `CRS_OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		acc(1'b0, `CRS_OFS_CORE_CFG, 32'h0);
		chk(q, 32'h1234_5678);
		chk(32'(cyc >= 40), 32'h1);
		chk(core_cfg, 32'h1234_5678);
		acc(1'b1, `CRS_OFS_CORE_CFG, 32'hCAFE_0001);
		acc(1'b1, `CRS_OFS_CORE_CFG, 32'hCAFE_0002);
		chk(32'(cyc >= 40), 32'h1);
		acc(1'b0, `CRS_OFS_SCRATCH, 32'h0);
		chk(32'(cyc), 32'h2);
		wait_idle();
		chk(core_cfg, 32'hCAFE_0002);
		acc(1'b1, `CRS_OFS_CTRL, 32'h2);
		acc(1'b0, `CRS_OFS_CTRL, 32'h0);
		chk(q, 32'h2);
		acc(1'b0, `CRS_OFS_CORE_CFG, 32'h0);
		chk(q, 32'hCAFE_0002);
		chk(32'(cyc), 32'h2);
		acc(1'b0, `CRS_OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		chk(32'(cyc), 32'h2);
		acc(1'b1, `CRS_OFS_SCRATCH, 32'h7);
		chk(32'(cyc >= 40), 32'h1);
		chk({31'h0, core_enable}, 32'h1);
		wait_idle();
		p = pend_cnt;
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(32'(cyc >= 104 && cyc <= 124), 32'h1);
		chk(32'(pend_cnt), 32'(p));
		chk(32'(q != 32'h0), 32'h1);
		acc(1'b1, `CRS_OFS_CORE_CFG, 32'h3);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(32'(cyc >= 150), 32'h1);
		acc(1'b1, `CRS_OFS_RD_REQ, 32'h0000_8014);
		acc(1'b0, `CRS_OFS_STATUS, 32'h0);
		chk(q, 32'h1);
		wait_idle();
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		v = q;
		chk(32'(cyc), 32'h2);
		repeat (200) @(posedge clk);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(q, v);
		acc(1'b1, `CRS_OFS_RD_REQ, 32'h0000_4014);
		wait_idle();
		p = pend_cnt;
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		v = q;
		repeat (300) @(posedge clk);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(32'(cyc), 32'h2);
		chk(32'(q > v), 32'h1);
		chk(32'(pend_cnt), 32'(p));
		run <= 1'b0;
		repeat (300) @(posedge clk);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		v = q;
		repeat (300) @(posedge clk);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(q, v);
		run <= 1'b1;
		acc(1'b1, `CRS_OFS_CORE_CFG, 32'h5);
		wait_idle();
		acc(1'b0, `CRS_OFS_RD_REQ, 32'h0);
		chk(q, 32'h0000_0014);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		v = q;
		repeat (300) @(posedge clk);
		acc(1'b0, `CRS_OFS_CORE_CNT, 32'h0);
		chk(q, v);
		acc(1'b1, `CRS_OFS_CTRL, 32'h1);
		acc(1'b0, `CRS_OFS_CTRL, 32'h0);
		chk({31'h0, q[0]}, 32'h1);
		wait_idle();
		acc(1'b0, `CRS_OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		chk(core_cfg, 32'h0);
		chk({31'h0, core_enable}, 32'h0);
		chk(32'(rst_cnt), 32'h1);
		close_out();
	end

	// Tests need about 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out();
	end
endmodule : common_register_synchronizer_tb_top

`default_nettype wire
